// ==== rtl/sfd_opcode_decoder.v ====
// instruction decoder of a serial nor flash, sampled on the system clock
// assumes sys_clk_in well above 2x the serial clock; pins arrive async
`timescale 1ns/1ps
`include "sfd_map.vh"

module sfd_opcode_decoder (
	input  wire       sys_clk_in,
	input  wire       rst_in,
	input  wire       sck_in,
	input  wire       cs_n_in,
	input  wire       io0_in,
	input  wire       long_addr_mode_in,
	input  wire       uniform_sector_in,
	output reg        cmd_valid_out,
	output reg  [7:0] opcode_out,
	output reg  [4:0] op_class_out,
	output reg        long_addr_out,
	output reg        large_sector_256k_out,
	output reg  [6:0] max_clk_mhz_out,
	output reg        unknown_cmd_out,
	output reg        frame_active_out
);

	localparam ST_IDLE  = 3'b001;
	localparam ST_SHIFT = 3'b010;
	localparam ST_DONE  = 3'b100;

	// the decode fires on the rise that brings the eighth bit
	localparam [3:0] LAST_BIT = `SFD_INSTR_BITS - 4'h1;

	reg       sck_prev_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [7:0] shift_r;
	reg [3:0] bit_cnt_r;
	reg [4:0] cls;
	reg       is_long;
	reg [6:0] fmax;

	wire       sck_q;
	wire       cs_n_q;
	wire       io0_q;
	wire       mode_q;
	wire       uni_q;
	wire       sck_rise;
	wire [7:0] byte_full;
	wire       last_bit;
	wire       decode_hit;

	// sck and io0 share one latency, so data lines up with the rise
	sfd_sync_two #(
		.RST_VAL(1'b0)
	) u_sync_sck (
		.sys_clk_in(sys_clk_in),
		.rst_in    (rst_in),
		.pin_in    (sck_in),
		.sync_out  (sck_q)
	);

	// resets deselected, so no false frame follows reset
	sfd_sync_two #(
		.RST_VAL(1'b1)
	) u_sync_cs (
		.sys_clk_in(sys_clk_in),
		.rst_in    (rst_in),
		.pin_in    (cs_n_in),
		.sync_out  (cs_n_q)
	);

	sfd_sync_two #(
		.RST_VAL(1'b0)
	) u_sync_io0 (
		.sys_clk_in(sys_clk_in),
		.rst_in    (rst_in),
		.pin_in    (io0_in),
		.sync_out  (io0_q)
	);

	sfd_sync_two #(
		.RST_VAL(1'b0)
	) u_sync_mode (
		.sys_clk_in(sys_clk_in),
		.rst_in    (rst_in),
		.pin_in    (long_addr_mode_in),
		.sync_out  (mode_q)
	);

	sfd_sync_two #(
		.RST_VAL(1'b0)
	) u_sync_uni (
		.sys_clk_in(sys_clk_in),
		.rst_in    (rst_in),
		.pin_in    (uniform_sector_in),
		.sync_out  (uni_q)
	);

	assign sck_rise   = sck_q & ~sck_prev_r;
	assign byte_full  = {shift_r[6:0], io0_q};
	assign last_bit   = sck_rise && (bit_cnt_r == LAST_BIT);
	assign decode_hit = (state_r == ST_SHIFT) && !cs_n_q && last_bit;

	// idle level of sck is low, so reset makes no false edge
	always @(posedge sys_clk_in) begin
		if (rst_in)
			sck_prev_r <= 1'b0;
		else
			sck_prev_r <= sck_q;
	end

	// classify the assembled byte
	always @* begin
		cls     = `SFD_CL_NONE;
		is_long = mode_q;
		fmax    = `SFD_FMAX_FULL_MHZ;
		case (byte_full)
			`SFD_OP_WRITE_STATUS_CONFIG: cls = `SFD_CL_WRITE_STATUS_CFG;
			`SFD_OP_PAGE_PROGRAM: cls = `SFD_CL_PAGE_PROGRAM;
			`SFD_OP_PAGE_PROGRAM_LONG: begin
				cls     = `SFD_CL_PAGE_PROGRAM;
				is_long = 1'b1;
			end
			`SFD_OP_BASIC_READ: begin
				cls  = `SFD_CL_BASIC_READ;
				fmax = `SFD_FMAX_SLOW_MHZ;
			end
			`SFD_OP_BASIC_READ_LONG: begin
				cls     = `SFD_CL_BASIC_READ;
				is_long = 1'b1;
				fmax    = `SFD_FMAX_SLOW_MHZ;
			end
			`SFD_OP_STATUS_ONE_READ: cls = `SFD_CL_STATUS_ONE_READ;
			`SFD_OP_STATUS_TWO_READ: cls = `SFD_CL_STATUS_TWO_READ;
			`SFD_OP_QUICK_READ: cls = `SFD_CL_QUICK_READ;
			`SFD_OP_QUICK_READ_LONG: begin
				cls     = `SFD_CL_QUICK_READ;
				is_long = 1'b1;
			end
			`SFD_OP_SMALL_ERASE: cls = `SFD_CL_SMALL_ERASE;
			`SFD_OP_SMALL_ERASE_LONG: begin
				cls     = `SFD_CL_SMALL_ERASE;
				is_long = 1'b1;
			end
			`SFD_OP_CLEAR_FAIL_FLAGS: cls = `SFD_CL_CLEAR_FAIL;
			`SFD_OP_FOUR_LANE_PROGRAM,
			`SFD_OP_FOUR_LANE_PROGRAM_ALT: begin
				cls  = `SFD_CL_FOUR_LANE_PROGRAM;
				fmax = `SFD_FMAX_QUAD_PP_MHZ;
			end
			`SFD_OP_FOUR_LANE_PROGRAM_LONG: begin
				cls     = `SFD_CL_FOUR_LANE_PROGRAM;
				is_long = 1'b1;
				fmax    = `SFD_FMAX_QUAD_PP_MHZ;
			end
			`SFD_OP_CONFIG_ONE_READ: cls = `SFD_CL_CONFIG_ONE_READ;
			`SFD_OP_TWO_OUT_READ: cls = `SFD_CL_TWO_OUT_READ;
			`SFD_OP_TWO_OUT_READ_LONG: begin
				cls     = `SFD_CL_TWO_OUT_READ;
				is_long = 1'b1;
			end
			`SFD_OP_FOUR_OUT_READ: cls = `SFD_CL_FOUR_OUT_READ;
			`SFD_OP_FOUR_OUT_READ_LONG: begin
				cls     = `SFD_CL_FOUR_OUT_READ;
				is_long = 1'b1;
			end
			`SFD_OP_TWO_IO_READ: cls = `SFD_CL_TWO_IO_READ;
			`SFD_OP_TWO_IO_READ_LONG: begin
				cls     = `SFD_CL_TWO_IO_READ;
				is_long = 1'b1;
			end
			`SFD_OP_FOUR_IO_READ: cls = `SFD_CL_FOUR_IO_READ;
			`SFD_OP_FOUR_IO_READ_LONG: begin
				cls     = `SFD_CL_FOUR_IO_READ;
				is_long = 1'b1;
			end
			`SFD_OP_DISCOVERABLE_READ: cls = `SFD_CL_DISCOVERABLE_READ;
			`SFD_OP_WHOLE_ERASE,
			`SFD_OP_WHOLE_ERASE_ALT: cls = `SFD_CL_WHOLE_ERASE;
			`SFD_OP_LARGE_ERASE: cls = `SFD_CL_LARGE_ERASE;
			`SFD_OP_LARGE_ERASE_LONG: begin
				cls     = `SFD_CL_LARGE_ERASE;
				is_long = 1'b1;
			end
			`SFD_OP_LEGACY_SIGNATURE: cls = `SFD_CL_LEGACY_SIGNATURE;
			`SFD_OP_IDENTIFICATION_READ: cls = `SFD_CL_IDENTIFICATION;
			`SFD_OP_BANK_ACCESS: cls = `SFD_CL_BANK_ACCESS;
			`SFD_OP_ELECTRONIC_SIGNATURE: begin
				cls  = `SFD_CL_ELECTRONIC_SIG;
				fmax = `SFD_FMAX_SLOW_MHZ;
			end
			`SFD_OP_CONTINUOUS_EXIT: cls = `SFD_CL_CONTINUOUS_EXIT;
			default: cls = `SFD_CL_NONE;
		endcase
	end

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (!cs_n_q)
					state_nxt = ST_SHIFT;
			ST_SHIFT:
				if (cs_n_q)
					state_nxt = ST_IDLE;
				else if (last_bit)
					state_nxt = ST_DONE;
			ST_DONE:
				if (cs_n_q)
					state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_r   <= ST_IDLE;
			shift_r   <= 8'h00;
			bit_cnt_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			if (state_r != ST_SHIFT) begin
				shift_r   <= 8'h00;
				bit_cnt_r <= 4'h0;
			end else if (sck_rise) begin
				shift_r   <= byte_full;
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
		end
	end

	// class and unknown flag clear when the frame ends, opcode, address, sector and limit hold to the next decode; pulse marks a known decode
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			cmd_valid_out         <= 1'b0;
			opcode_out            <= 8'h00;
			op_class_out          <= `SFD_CL_NONE;
			long_addr_out         <= 1'b0;
			large_sector_256k_out <= 1'b0;
			max_clk_mhz_out       <= `SFD_FMAX_FULL_MHZ;
			unknown_cmd_out       <= 1'b0;
			frame_active_out      <= 1'b0;
		end else begin
			frame_active_out <= ~cs_n_q;
			cmd_valid_out    <= 1'b0;
			if (decode_hit) begin
				cmd_valid_out         <= (cls != `SFD_CL_NONE);
				unknown_cmd_out       <= (cls == `SFD_CL_NONE);
				opcode_out            <= byte_full;
				op_class_out          <= cls;
				long_addr_out         <= is_long;
				large_sector_256k_out <= uni_q;
				max_clk_mhz_out       <= fmax;
			end else if (cs_n_q) begin
				op_class_out    <= `SFD_CL_NONE;
				unknown_cmd_out <= 1'b0;
			end
		end
	end

endmodule

// two-flop synchroniser for one asynchronous pin
// only the second stage leaves this module
module sfd_sync_two #(
	parameter [0:0] RST_VAL = 1'b0
) (
	input  wire sys_clk_in,
	input  wire rst_in,
	input  wire pin_in,
	output wire sync_out
);

	reg meta_r;
	reg sync_r;

	// first stage may go metastable; never read outside
	always @(posedge sys_clk_in) begin
		if (rst_in) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

endmodule

// ==== shared/sfd_map.vh ====
// opcode codes, operation classes and clock limits for the decoder
// included by the decoder; holds definitions only
`ifndef SFD_MAP_VH
`define SFD_MAP_VH

`define SFD_OP_WRITE_STATUS_CONFIG   8'h01
`define SFD_OP_PAGE_PROGRAM          8'h02
`define SFD_OP_BASIC_READ            8'h03
`define SFD_OP_STATUS_ONE_READ       8'h05
`define SFD_OP_STATUS_TWO_READ       8'h07
`define SFD_OP_QUICK_READ            8'h0B
`define SFD_OP_QUICK_READ_LONG       8'h0C
`define SFD_OP_PAGE_PROGRAM_LONG     8'h12
`define SFD_OP_BASIC_READ_LONG       8'h13
`define SFD_OP_SMALL_ERASE           8'h20
`define SFD_OP_SMALL_ERASE_LONG      8'h21
`define SFD_OP_CLEAR_FAIL_FLAGS      8'h30
`define SFD_OP_FOUR_LANE_PROGRAM     8'h32
`define SFD_OP_FOUR_LANE_PROGRAM_LONG 8'h34
`define SFD_OP_CONFIG_ONE_READ       8'h35
`define SFD_OP_FOUR_LANE_PROGRAM_ALT 8'h38
`define SFD_OP_TWO_OUT_READ          8'h3B
`define SFD_OP_TWO_OUT_READ_LONG     8'h3C
`define SFD_OP_DISCOVERABLE_READ     8'h5A
`define SFD_OP_WHOLE_ERASE           8'h60
`define SFD_OP_FOUR_OUT_READ         8'h6B
`define SFD_OP_FOUR_OUT_READ_LONG    8'h6C
`define SFD_OP_LEGACY_SIGNATURE      8'h90
`define SFD_OP_IDENTIFICATION_READ   8'h9F
`define SFD_OP_ELECTRONIC_SIGNATURE  8'hAB
`define SFD_OP_BANK_ACCESS           8'hB9
`define SFD_OP_TWO_IO_READ           8'hBB
`define SFD_OP_TWO_IO_READ_LONG      8'hBC
`define SFD_OP_WHOLE_ERASE_ALT       8'hC7
`define SFD_OP_LARGE_ERASE           8'hD8
`define SFD_OP_LARGE_ERASE_LONG      8'hDC
`define SFD_OP_FOUR_IO_READ          8'hEB
`define SFD_OP_FOUR_IO_READ_LONG     8'hEC
`define SFD_OP_CONTINUOUS_EXIT       8'hFF

// operation class codes on op_class_out
`define SFD_CL_NONE              5'h00
`define SFD_CL_WRITE_STATUS_CFG  5'h01
`define SFD_CL_PAGE_PROGRAM      5'h02
`define SFD_CL_BASIC_READ        5'h03
`define SFD_CL_STATUS_ONE_READ   5'h04
`define SFD_CL_STATUS_TWO_READ   5'h05
`define SFD_CL_QUICK_READ        5'h06
`define SFD_CL_SMALL_ERASE       5'h07
`define SFD_CL_CLEAR_FAIL        5'h08
`define SFD_CL_FOUR_LANE_PROGRAM 5'h09
`define SFD_CL_CONFIG_ONE_READ   5'h0A
`define SFD_CL_TWO_OUT_READ      5'h0B
`define SFD_CL_FOUR_OUT_READ     5'h0C
`define SFD_CL_TWO_IO_READ       5'h0D
`define SFD_CL_FOUR_IO_READ      5'h0E
`define SFD_CL_DISCOVERABLE_READ 5'h0F
`define SFD_CL_WHOLE_ERASE       5'h10
`define SFD_CL_LARGE_ERASE       5'h11
`define SFD_CL_LEGACY_SIGNATURE  5'h12
`define SFD_CL_IDENTIFICATION    5'h13
`define SFD_CL_BANK_ACCESS       5'h14
`define SFD_CL_ELECTRONIC_SIG    5'h15
`define SFD_CL_CONTINUOUS_EXIT   5'h16

// highest serial clock per command, MHz
`define SFD_FMAX_SLOW_MHZ    7'h32
`define SFD_FMAX_QUAD_PP_MHZ 7'h50
`define SFD_FMAX_FULL_MHZ    7'h6C

// instruction length in serial clocks
`define SFD_INSTR_BITS 4'h8

`endif

// ==== verif/sfd_host_model.sv ====
// host model: one instruction frame per frame() call
// paced by the bench clock; the lane toggles while deselected
`timescale 1ns/1ps
module sfd_host_model (
	input  wire clk_in,
	output reg  sck_out,
	output reg  cs_n_out,
	output reg  io0_out
);
	initial {sck_out, cs_n_out, io0_out} = 3'b010;
	// a released lane holds no value
	always @(posedge clk_in)
		if (cs_n_out)
			io0_out <= ~io0_out;
	task frame(input logic [7:0] b, input int nb, input int hp);
		int i;
		@(posedge clk_in);
		#1 cs_n_out = 1'b0;
		for (i = 0; i < nb; i++) begin
			io0_out = (i < 8) ? b[7 - i] : 1'b1;
			repeat (hp) @(posedge clk_in);
			#1 sck_out = 1'b1;
			repeat (hp) @(posedge clk_in);
			#1 sck_out = 1'b0;
		end
		repeat (hp) @(posedge clk_in);
		#1 cs_n_out = 1'b1;
		repeat (5) @(posedge clk_in);
		#1;
	endtask
endmodule

// ==== verif/sfd_opcode_decoder_checker.sv ====
// port assertions for the instruction decoder
// bound from the bench top; one clock domain
`timescale 1ns/1ps
module sfd_opcode_decoder_checker (
	input wire       sys_clk_in,
	input wire       rst_in,
	input wire       cs_n_in,
	input wire       cmd_valid_out,
	input wire [7:0] opcode_out,
	input wire [4:0] op_class_out,
	input wire       long_addr_out,
	input wire [6:0] max_clk_mhz_out,
	input wire       unknown_cmd_out,
	input wire       frame_active_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	wire       v = cmd_valid_out;
	wire [7:0] op = opcode_out;
	wire [4:0] c = op_class_out;
	wire [6:0] f = max_clk_mhz_out;
	// limits: 7'h32 is 50 MHz, 7'h50 is 80, 7'h6C is 108
	property p_pulse; v |=> !v; endproperty
	a_pulse: assert property (p_pulse) else $error("valid too long");
	property p_slow; v && op inside {8'h03, 8'h13} |-> f == 7'h32; endproperty
	a_slow: assert property (p_slow) else $error("read limit");
	property p_sig; v && op == 8'hAB |-> f == 7'h32 && c == 5'h15; endproperty
	a_sig: assert property (p_sig) else $error("signature");
	property p_quad; v && op inside {8'h32, 8'h34, 8'h38}
		|-> f == 7'h50 && c == 5'h09; endproperty
	a_quad: assert property (p_quad) else $error("quad program");
	property p_fast; v && op inside {8'h0B, 8'h0C}
		|-> f == 7'h6C && c == 5'h06; endproperty
	a_fast: assert property (p_fast) else $error("fast read");
	property p_long; v && op inside {8'h0C, 8'h12, 8'h13, 8'h21, 8'h34,
		8'h3C, 8'h6C, 8'hBC, 8'hDC, 8'hEC} |-> long_addr_out; endproperty
	a_long: assert property (p_long) else $error("address length");
	property p_clear; cs_n_in [*5]
		|-> c == 5'h00 && !unknown_cmd_out && !frame_active_out; endproperty
	a_clear: assert property (p_clear) else $error("not idle");
	property p_act; !cs_n_in [*5] |-> frame_active_out; endproperty
	a_act: assert property (p_act) else $error("frame unseen");
	c_valid: cover property (v);
	c_unk: cover property (unknown_cmd_out);
	c_quad: cover property (v && f == 7'h50);
endmodule

// ==== verif/tb_spi_flash_opcode_decoder.sv ====
// self-checking bench for the instruction decoder
// host model drives the pins; checker bound at the foot
`timescale 1ns/1ps
module tb_spi_flash_opcode_decoder;
	logic       sys_clk, rst, long_mode, uni, unk;
	wire        sck, cs_n, io0, cmd_valid_out, long_addr_out;
	wire        large_sector_256k_out, unknown_cmd_out, frame_active_out;
	wire  [7:0] opcode_out;
	wire  [4:0] op_class_out;
	wire  [6:0] max_clk_mhz_out;
	logic [4:0] v_cls;
	int         err_total = 0, checked = 0, n_v;
	localparam logic [7:0] op_tab [34] = '{8'h01, 8'h02, 8'h12, 8'h03,
		8'h13, 8'h05, 8'h07, 8'h0B, 8'h0C, 8'h20, 8'h21, 8'h30, 8'h32,
		8'h34, 8'h38, 8'h35, 8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB, 8'hBC,
		8'hEB, 8'hEC, 8'h5A, 8'h60, 8'hC7, 8'hD8, 8'hDC, 8'h90, 8'h9F,
		8'hB9, 8'hAB, 8'hFF};
	localparam logic [4:0] cls_tab [34] = '{5'h01, 5'h02, 5'h02, 5'h03,
		5'h03, 5'h04, 5'h05, 5'h06, 5'h06, 5'h07, 5'h07, 5'h08, 5'h09,
		5'h09, 5'h09, 5'h0A, 5'h0B, 5'h0B, 5'h0C, 5'h0C, 5'h0D, 5'h0D,
		5'h0E, 5'h0E, 5'h0F, 5'h10, 5'h10, 5'h11, 5'h11, 5'h12, 5'h13,
		5'h14, 5'h15, 5'h16};

	sfd_host_model u_sfd_host_model (.clk_in(sys_clk), .sck_out(sck),
		.cs_n_out(cs_n), .io0_out(io0));
	sfd_opcode_decoder u_sfd_opcode_decoder (.sys_clk_in(sys_clk),
		.rst_in(rst), .sck_in(sck), .cs_n_in(cs_n), .io0_in(io0),
		.long_addr_mode_in(long_mode), .uniform_sector_in(uni),
		.cmd_valid_out(cmd_valid_out), .opcode_out(opcode_out),
		.op_class_out(op_class_out), .long_addr_out(long_addr_out),
		.large_sector_256k_out(large_sector_256k_out),
		.max_clk_mhz_out(max_clk_mhz_out),
		.unknown_cmd_out(unknown_cmd_out),
		.frame_active_out(frame_active_out));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// class is cleared at frame end, so take it at the pulse
	always @(posedge sys_clk) begin
		if (cmd_valid_out === 1'b1) begin
			n_v++;
			v_cls = op_class_out;
		end
		if (unknown_cmd_out === 1'b1)
			unk = 1'b1;
	end

	task check(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function logic [4:0] cls_of(input logic [7:0] op);
		cls_of = 5'h00;
		for (int k = 0; k < 34; k++)
			if (op_tab[k] == op)
				cls_of = cls_tab[k];
	endfunction

	task run(input logic [7:0] op, input int nb);
		logic [4:0] c;
		logic       m, u, lg;
		m = 1'($urandom);
		u = 1'($urandom);
		@(posedge sys_clk);
		#1 long_mode = m;
		uni = u;
		n_v = 0;
		unk = 1'b0;
		u_sfd_host_model.frame(op, nb, 3 + $urandom_range(2));
		c = (nb >= 8) ? cls_of(op) : 5'h00;
		lg = m | (op inside {8'h0C, 8'h12, 8'h13, 8'h21, 8'h34, 8'h3C,
			8'h6C, 8'hBC, 8'hDC, 8'hEC});
		check("valid count", n_v, c != 5'h00);
		check("unknown", unk, nb >= 8 && c == 5'h00);
		if (c != 5'h00) begin
			check("class", v_cls, c);
			check("opcode", opcode_out, op);
			check("fmax", max_clk_mhz_out, (op inside {8'h03, 8'h13,
				8'hAB}) ? 7'h32 : (op inside {8'h32, 8'h34, 8'h38})
				? 7'h50 : 7'h6C);
			if (c inside {5'h02, 5'h03, 5'h06, 5'h07, 5'h09, 5'h0B,
				5'h0C, 5'h0D, 5'h0E, 5'h11})
				check("long", long_addr_out, lg);
			if (c == 5'h11)
				check("sector", large_sector_256k_out, u);
		end
		check("idle class", op_class_out, 5'h00);
		check("idle unknown", unknown_cmd_out, 1'b0);
		check("idle frame", frame_active_out, 1'b0);
	endtask

	initial begin
		void'($urandom(1));
		{rst, long_mode, uni} = 3'b100;
		repeat (2) @(posedge sys_clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < 256; i++)
			run(8'(i), 8);
		// extra bits after known and unknown bytes, then an aborted byte
		run(8'h0B, 12);
		run(8'h04, 16);
		run(8'hEB, 5);
		for (int i = 0; i < 40; i++)
			run(8'($urandom), 8);
		run(8'h03, 8);
		#1 rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 check("reset fmax", max_clk_mhz_out, 7'h6C);
		rst = 1'b0;
		run(8'h9F, 8);
		wrap_up;
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		err_total++;
		wrap_up;
	end
endmodule

bind sfd_opcode_decoder sfd_opcode_decoder_checker u_chk (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in),
	.cmd_valid_out(cmd_valid_out), .opcode_out(opcode_out),
	.op_class_out(op_class_out), .long_addr_out(long_addr_out),
	.max_clk_mhz_out(max_clk_mhz_out), .unknown_cmd_out(unknown_cmd_out),
	.frame_active_out(frame_active_out));
